// ==== pnm_map.vh ====
// Constants for the process noise ratio monitor
`ifndef PNM_MAP_VH
`define PNM_MAP_VH

// Fixed ratio threshold (carrier vs noise)
`define PNM_RATIO_THRESH      16'h0019
// Hold time below threshold before alert, in seconds
`define PNM_HOLD_SEC          60
// Clock rate in Hz
`define PNM_CLK_HZ            40000000
// Hold time in clock cycles
`define PNM_HOLD_CYCLES       (`PNM_HOLD_SEC * `PNM_CLK_HZ)
// Drive mode codes
`define PNM_MODE_LOW          1'b0
`define PNM_MODE_HIGH         1'b1

`endif

// ==== pnm_monitor.v ====
// Process noise ratio monitor: side-band noise, ratio outputs and alert
`timescale 1ns/1ps
`include "pnm_map.vh"

module pnm_monitor #(
    parameter AMP_W       = 16,
    parameter RATIO_W     = 16,
    parameter HOLD_CYCLES = `PNM_HOLD_CYCLES
) (
    // Clock and reset
    input  wire               clk,
    input  wire               rst_n,
    // Control
    input  wire               diag_enable,
    input  wire               drive_mode,
    input  wire               flow_ok,
    // Spectrum amplitudes, qualified by amp_valid
    input  wire               amp_valid,
    input  wire [AMP_W-1:0]   amp_low_carrier,
    input  wire [AMP_W-1:0]   amp_low_side_a,
    input  wire [AMP_W-1:0]   amp_low_side_b,
    input  wire [AMP_W-1:0]   amp_high_carrier,
    input  wire [AMP_W-1:0]   amp_high_side_a,
    input  wire [AMP_W-1:0]   amp_high_side_b,
    // Results
    output reg  [RATIO_W-1:0] low_drive_noise_ratio,
    output reg  [RATIO_W-1:0] high_drive_noise_ratio,
    output reg                low_ratio_bad,
    output reg                high_ratio_bad,
    output reg                noise_alert
);

    localparam CNT_W = 32;
    localparam [CNT_W-1:0] HOLD_LAST = HOLD_CYCLES - 1;

    // Timing at a glance
    //   Edge n:    amp_valid high, amplitudes taken.
    //   Edge n:    ratios and verdicts load, visible from then on.
    //   Edge n+1:  first count of a bad active verdict.
    //   Alert:     rises once the count reaches HOLD_CYCLES-1 and stays bad.
    //   Clear:     the edge after the verdict recovers, judging drops or mode moves.
    //
    // Persistence counter
    //   32 bits wide, enough for one minute of a 40 MHz clock.
    //   Default hold of one minute is 2,400,000,000 cycles.
    //   Benches shorten HOLD_CYCLES to keep runs brief.
    //   Counter stops at HOLD_CYCLES-1 rather than wrapping.
    //
    // Noise level
    //   Mean of the two side bands, truncated towards zero.
    //   Sum formed one bit wider so it never overflows.
    //
    // Ratio values
    //   Integer floor of carrier over noise.
    //   Zero noise reads as full scale.
    //   Saturates if the quotient does not fit RATIO_W.
    //   Held between spectra; amp_valid low leaves them alone.
    //
    // Threshold verdict
    //   Exact product test, carrier below 25 times noise.
    //   No rounding error from the division above.
    //   Both bands judged every spectrum, whichever mode is active.
    //
    // Alert
    //   Level output, never latched.
    //   Suppressed while disabled or without flow.
    //   Restarted by any change of drive mode.
    //   Only the active mode's verdict feeds it.
    //
    // Hazards for users
    //   drive_mode, diag_enable and flow_ok must come from this clock domain.
    //   Mode code 0 is the 5 Hz drive, 1 the 37 Hz drive.
    //   A spectrum every cycle is allowed; nothing is refused.
    //   All outputs clear to zero on reset.
    //

    // Mean of two side-band amplitudes
    function [AMP_W-1:0] side_mean;
        input [AMP_W-1:0] a;
        input [AMP_W-1:0] b;
        reg   [AMP_W:0]   s;
        begin
            s = {1'b0, a} + {1'b0, b};
            side_mean = s[AMP_W:1];
        end
    endfunction

    // Carrier over noise, saturated; zero noise gives full scale
    function [RATIO_W-1:0] ratio_of;
        input [AMP_W-1:0] carrier;
        input [AMP_W-1:0] noise;
        reg   [AMP_W-1:0] q;
        begin
            if (noise == {AMP_W{1'b0}}) begin
                ratio_of = {RATIO_W{1'b1}};
            end else begin
                q = carrier / noise;
                if (AMP_W > RATIO_W && (q >> RATIO_W) != 0)
                    ratio_of = {RATIO_W{1'b1}};
                else
                    ratio_of = q[RATIO_W-1:0];
            end
        end
    endfunction

    // Below-threshold test: carrier < 25 * noise, exact with no division error
    function below_thresh;
        input [AMP_W-1:0] carrier;
        input [AMP_W-1:0] noise;
        reg   [AMP_W+15:0] lim;
        begin
            lim = noise * `PNM_RATIO_THRESH;
            below_thresh = ({16'h0000, carrier} < lim);
        end
    endfunction

    // Side-band noise levels per drive mode
    wire [AMP_W-1:0]   low_noise;
    wire [AMP_W-1:0]   high_noise;

    // Next values of the ratio registers
    reg  [RATIO_W-1:0] low_ratio_d;
    reg  [RATIO_W-1:0] high_ratio_d;
    reg                low_bad_d;
    reg                high_bad_d;

    // Persistence state and next values
    reg  [CNT_W-1:0]   hold_q;
    reg  [CNT_W-1:0]   hold_d;
    reg                mode_q;
    reg                alert_d;

    // Decoded conditions
    wire               active_bad;
    wire               judging;
    wire               mode_moved;
    wire               hold_done;

    assign low_noise  = side_mean(amp_low_side_a, amp_low_side_b);
    assign high_noise = side_mean(amp_high_side_a, amp_high_side_b);

    // next ratio values, held between spectra
    always @* begin
        low_ratio_d  = low_drive_noise_ratio;
        high_ratio_d = high_drive_noise_ratio;
        low_bad_d    = low_ratio_bad;
        high_bad_d   = high_ratio_bad;
        if (amp_valid) begin
            low_ratio_d  = ratio_of(amp_low_carrier, low_noise);
            high_ratio_d = ratio_of(amp_high_carrier, high_noise);
            low_bad_d    = below_thresh(amp_low_carrier, low_noise);
            high_bad_d   = below_thresh(amp_high_carrier, high_noise);
        end
    end

    // Ratio and verdict registers
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            low_drive_noise_ratio  <= {RATIO_W{1'b0}};
            high_drive_noise_ratio <= {RATIO_W{1'b0}};
            low_ratio_bad          <= 1'b0;
            high_ratio_bad         <= 1'b0;
        end else begin
            low_drive_noise_ratio  <= low_ratio_d;
            high_drive_noise_ratio <= high_ratio_d;
            low_ratio_bad          <= low_bad_d;
            high_ratio_bad         <= high_bad_d;
        end
    end

    // fixed threshold, mode selects the active verdict
    assign active_bad = (drive_mode == `PNM_MODE_HIGH) ? high_ratio_bad : low_ratio_bad;
    // judge only with flow and enabled
    assign judging    = diag_enable & flow_ok;
    // Mode change restarts the minute
    assign mode_moved = (mode_q != drive_mode);
    // Hold time used up
    assign hold_done  = (hold_q >= HOLD_LAST);

    always @* begin
        hold_d  = hold_q;
        alert_d = noise_alert;
        if (!judging || !active_bad || mode_moved) begin
            // alert clears when ratio recovers or diagnostic off
            hold_d  = {CNT_W{1'b0}};
            alert_d = 1'b0;
        end else if (hold_done) begin
            alert_d = 1'b1;
        end else begin
            hold_d  = hold_q + 1'b1;
        end
    end

    // Counter, mode and alert registers
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_q      <= {CNT_W{1'b0}};
            mode_q      <= `PNM_MODE_LOW;
            noise_alert <= 1'b0;
        end else begin
            hold_q      <= hold_d;
            mode_q      <= drive_mode;
            noise_alert <= alert_d;
        end
    end

endmodule // pnm_monitor

// ==== pnm_sensor.sv ====
// Flow sensor electrode spectrum model
`timescale 1ns/1ps
module pnm_sensor (
    // Carrier and noise levels per band
    input wire [15:0] cl, nl, ch, nh,
    // Spectrum amplitudes
    output wire [15:0] amp_low_carrier, amp_low_side_a, amp_low_side_b,
    output wire [15:0] amp_high_carrier, amp_high_side_a, amp_high_side_b);
    // Side bands a quarter either side of the noise level
    assign {amp_low_carrier, amp_low_side_a, amp_low_side_b} = {cl, nl - nl[15:2], nl + nl[15:2]};
    assign {amp_high_carrier, amp_high_side_a, amp_high_side_b} = {ch, nh - nh[15:2], nh + nh[15:2]};
endmodule // pnm_sensor

// ==== pnm_chk_monitor.sv ====
// Checker for the noise ratio monitor
`timescale 1ns/1ps
module pnm_chk #(parameter AMP_W = 16, RATIO_W = 16) (
    input wire clk, rst_n, diag_enable, drive_mode, flow_ok, amp_valid,
    input wire [AMP_W-1:0] amp_low_carrier, amp_low_side_a, amp_low_side_b,
    input wire [AMP_W-1:0] amp_high_carrier, amp_high_side_a, amp_high_side_b,
    input wire [RATIO_W-1:0] low_drive_noise_ratio, high_drive_noise_ratio,
    input wire low_ratio_bad, high_ratio_bad, noise_alert);
    // Flags expected from the side-band mean
    wire [AMP_W:0] sl = amp_low_side_a + amp_low_side_b, sh = amp_high_side_a + amp_high_side_b;
    wire lb = amp_low_carrier < 25 * sl[AMP_W:1], hb = amp_high_carrier < 25 * sh[AMP_W:1];
    wire act = drive_mode ? high_ratio_bad : low_ratio_bad;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_LO: assert property (amp_valid |=> low_ratio_bad == $past(lb)) else $error("lo");
    AST_HI: assert property (amp_valid |=> high_ratio_bad == $past(hb)) else $error("hi");
    AST_ZERO: assert property (amp_valid && sl < 2 |=> &low_drive_noise_ratio) else $error("z");
    AST_KEEP: assert property (!amp_valid |=> $stable(high_drive_noise_ratio)) else $error("k");
    AST_OFF: assert property (!(diag_enable & flow_ok) |=> !noise_alert) else $error("off");
    AST_DROP: assert property (!act |=> !noise_alert) else $error("drop");
    AST_WAIT: assert property ($rose(noise_alert) |-> $past(act, 10)) else $error("wait");
    AST_MODE: assert property ($changed(drive_mode) |=> !noise_alert) else $error("mode");
endmodule // pnm_chk
bind pnm_monitor pnm_chk #(.AMP_W(AMP_W), .RATIO_W(RATIO_W)) chk (.*);

// ==== testbench.sv ====
// Self-checking bench for the noise ratio monitor
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin miscompares++; \
$display("[ERR] %0t %h %h", $time, a, e); end end
module testbench;
    reg clk = 0, rst_n = 0, diag_enable = 1, drive_mode = 0, flow_ok = 1, amp_valid = 0;
    reg [15:0] cl = 0, nl = 0, ch = 0, nh = 0;
    wire [15:0] amp_low_carrier, amp_low_side_a, amp_low_side_b, amp_high_carrier,
        amp_high_side_a, amp_high_side_b, low_drive_noise_ratio, high_drive_noise_ratio;
    wire low_ratio_bad, high_ratio_bad, noise_alert;
    integer seed = 32'hdb83, miscompares = 0, n_compared = 0, i;
    always #12.5 clk = ~clk;
    pnm_sensor sen (.*);
    pnm_monitor #(.HOLD_CYCLES(20)) dut (.*);
    // Ratio and bad flag for one band
    function [16:0] ex(input [15:0] c, n);
        ex = {n ? c / n : 16'hffff, c < 25 * n};
    endfunction
    task step(input [15:0] a, b, c, d);
        {cl, nl, ch, nh} = {a, b, c, d};
        @(posedge clk) #2;
        `CHK({low_drive_noise_ratio, low_ratio_bad}, ex(a, b))
        `CHK({high_drive_noise_ratio, high_ratio_bad}, ex(c, d))
    endtask
    task end_sim;
        $display("%0d compared, %0d wrong", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        #2 rst_n = 1;
        amp_valid = 1;
        // Random bands, ratio 25 against 24, then no noise
        repeat (300) begin
            {drive_mode, flow_ok} = $random(seed);
            step($random(seed), $random(seed) & 2047, $random(seed), $random(seed) & 2047);
        end
        step(2500, 100, 2499, 100);
        step(7, 0, 0, 0);
        $display("ratios done");
        // Dwell in each mode, then with diagnostic off, then with no flow
        for (i = 0; i < 4; i++) begin
            {diag_enable, flow_ok, drive_mode} = {i != 2, i != 3, i[0]};
            repeat (20) step(i[0] ? 5000 : 100, 100, i[0] ? 100 : 5000, 100);
            `CHK(noise_alert, 1'b0)
            repeat (6) step(i[0] ? 5000 : 100, 100, i[0] ? 100 : 5000, 100);
            `CHK(noise_alert, i < 2)
            repeat (2) step(5000, 100, 5000, 100);
            `CHK(noise_alert, 1'b0)
        end
        $display("alert done");
        // Ratios hold while no sample is offered
        amp_valid = 0;
        cl = 7;
        @(posedge clk) #2;
        `CHK(low_drive_noise_ratio, 16'h0032)
        $display("hold done");
        end_sim;
    end
endmodule // testbench
